//--- uusl_pkg.sv
package uusl_pkg;

  // tick timing: one application and position-loop pass per millisecond
  localparam int CLOCK_PERIOD_NS = 8;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLOCK_PERIOD_NS;
  localparam int TICK_CNT_W = 32;

  // intermediate width for the ratio products before the single division
  localparam int CW = 224;

  // object indices and subindices
  localparam logic [15:0] OBJ_ENC = 16'h608F;
  localparam logic [15:0] OBJ_GEAR = 16'h6091;
  localparam logic [15:0] OBJ_FEED = 16'h6092;
  localparam logic [15:0] OBJ_VFAC = 16'h6096;
  localparam logic [15:0] OBJ_AFAC = 16'h6097;
  localparam logic [15:0] OBJ_JFAC = 16'h60A2;
  localparam logic [15:0] OBJ_POSU = 16'h60A8;
  localparam logic [15:0] OBJ_SPDU = 16'h60A9;
  localparam logic [15:0] OBJ_VMFAC = 16'h604C;
  localparam logic [15:0] OBJ_TOL = 16'h2056;
  localparam logic [15:0] OBJ_SWLIM = 16'h607D;
  localparam logic [15:0] OBJ_LIMEN = 16'h3700;
  localparam logic [15:0] OBJ_STAT = 16'h3701;
  localparam logic [7:0] SUB_WORD = 8'h00;
  localparam logic [7:0] SUB_NUM = 8'h01;
  localparam logic [7:0] SUB_DEN = 8'h02;

  // storage slots
  localparam int S_ENC_INC = 0, S_ENC_REV = 1, S_GEAR_M = 2, S_GEAR_S = 3;
  localparam int S_FEED = 4, S_FEED_S = 5, S_VNUM = 6, S_VDEN = 7;
  localparam int S_ANUM = 8, S_ADEN = 9, S_JNUM = 10, S_JDEN = 11;
  localparam int S_POSU = 12, S_SPDU = 13, S_VMNUM = 14, S_VMDEN = 15;
  localparam int S_TOL = 16, S_SWMIN = 17, S_SWMAX = 18, S_LIMEN = 19;
  localparam int NSLOT = 20;
  localparam int S_NONE = -1;

  localparam logic [31:0] POSU_RPM_WORD = 32'h00B44700;
  localparam logic [31:0] SLOT_RESET [NSLOT] = '{
    32'h00000001, 32'h00000001, 32'h00000001, 32'h00000001,
    32'h00000001, 32'h00000001, 32'h00000001, 32'h00000001,
    32'h00000001, 32'h00000001, 32'h00000001, 32'h00000001,
    32'hFF410000, POSU_RPM_WORD, 32'h00000001, 32'h00000001,
    32'h00000000, 32'h80000000, 32'h7FFFFFFF, 32'h00000000};

  // unit word fields
  localparam int TIME_LSB = 8;
  localparam int POS_UNIT_LSB = 16;
  localparam int EXP_LSB = 24;
  localparam logic [31:0] POSU_MASK = 32'hFFFF0000;
  localparam logic [31:0] SPDU_MASK = 32'hFFFFFF00;
  localparam logic signed [7:0] EXP_MAX = 8'sh06;

  localparam logic [7:0] UNIT_DIMLESS = 8'h00;
  localparam logic [7:0] UNIT_METER = 8'h01;
  localparam logic [7:0] UNIT_DEGREE = 8'h41;
  localparam logic [7:0] UNIT_REV = 8'hB4;
  localparam logic [7:0] UNIT_INC = 8'hB5;
  localparam logic [7:0] TIME_SEC = 8'h03;
  localparam logic [7:0] TIME_MIN = 8'h47;
  localparam logic [7:0] TIME_HOUR = 8'h48;
  localparam logic [7:0] TIME_DAY = 8'h49;
  localparam logic [7:0] TIME_YEAR = 8'h4A;
  localparam logic [31:0] DEG_PER_REV = 32'h00000168;
  localparam logic [31:0] SEC_PER_MIN = 32'h0000003C;
  localparam logic [31:0] SEC_PER_HOUR = 32'h00000E10;
  localparam logic [31:0] SEC_PER_DAY = 32'h00015180;
  localparam logic [31:0] SEC_PER_YEAR = 32'h01E187E0;

  localparam int NITEM = 6;
  localparam logic [2:0] IT_POS = 3'h0, IT_SPD = 3'h1, IT_ACC = 3'h2;
  localparam logic [2:0] IT_JRK = 3'h3, IT_MIN = 3'h4, IT_MAX = 3'h5;

  typedef enum logic [1:0] {
    UUSL_IDLE = 2'b00,
    UUSL_CALC = 2'b01,
    UUSL_APPLY = 2'b10
  } uusl_state_t;

endpackage : uusl_pkg

//--- uusl_core.sv
// How it works
// R1: encoder resolution is encoder increments over motor revolutions
// R2: gear ratio is motor revolutions over shaft revolutions
// R3: feed constant is feed over shaft revolutions
// R4: feed constant used only for length or dimensionless position units
// R5: position word: unit bits 16-23, exponent 24-31, low 16 bits zero
// R6: speed word: time unit 8-15, position unit 16-23, exponent 24-31
// R7: velocity mode speed unit fixed rpm, scaled only by its own factor
// R8: speeds scaled by velocity numerator over denominator
// R9: acceleration is speed unit per second times its own ratio
// R10: jerk is acceleration unit per second times its own ratio
// R11: limit inputs act only when enabled in configuration
// R12: free motion inside tolerance zone past each limit switch
// R13: entering the forbidden range gives immediate stop and fault
// R14: demand position never exceeds the software limits; a forbidden-range stop sets it to ACTUAL_POS without clamping
// R15: outside the limits only commands heading back are accepted
// R16: application data and position loop run every 1 ms tick
// R17: values and input levels sampled once per tick
// R18: scaling changes wait until operation-enabled is left
// R19: meter uses gear and feed; degree and revolution gear only
// R20: exponent byte is signed power of ten, -6 to +6
// R21: ratio products kept wide until the final division
`timescale 1ns/1ps
module uusl_core
  import uusl_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic OBJ_REQ,
  input wire logic OBJ_WE,
  input wire logic [15:0] OBJ_INDEX,
  input wire logic [7:0] OBJ_SUB,
  input wire logic [31:0] OBJ_WDATA,
  output logic OBJ_ACK,
  output logic OBJ_ERR,
  output logic [31:0] OBJ_RDATA,
  input wire logic [31:0] TARGET_POS,
  input wire logic [31:0] TARGET_SPEED,
  input wire logic [31:0] TARGET_ACCEL,
  input wire logic [31:0] TARGET_JERK,
  input wire logic [31:0] ACTUAL_POS,
  input wire logic LIMIT_NEG,
  input wire logic LIMIT_POS,
  input wire logic OP_ENABLED,
  input wire logic VELOCITY_MODE,
  input wire logic FAULT_RESET,
  output logic [31:0] DEMAND_POS,
  output logic [31:0] SPEED_DEMAND,
  output logic [31:0] ACCEL_DEMAND,
  output logic [31:0] JERK_DEMAND,
  output logic FAULT,
  output logic IMM_STOP,
  output logic CMD_REJECT,
  output logic TICK
);

  logic [TICK_CNT_W-1:0] tick_cnt, next_tick_cnt;
  logic [1:0] lim_s1, lim_s2, lim_s3, lim_stable, next_lim_stable;
  logic [31:0] pend [NSLOT];
  logic [31:0] act [NSLOT];
  logic [31:0] next_pend [NSLOT];
  logic [31:0] next_act [NSLOT];
  logic next_ack, next_err;
  logic [31:0] next_rdata;
  int slot;
  uusl_state_t state, next_state;
  logic [2:0] item, next_item;
  logic [31:0] snap [4];
  logic [31:0] next_snap [4];
  logic [31:0] res [NITEM];
  logic [31:0] next_res [NITEM];
  logic [31:0] apos, next_apos, ref_neg, next_ref_neg, ref_pos, next_ref_pos;
  logic [1:0] lim_act, next_lim_act;
  logic velmode, next_velmode;
  logic next_fault, next_reject, forbidden;
  logic [31:0] next_demand, next_speed, next_accel, next_jerk;
  logic [CW-1:0] num, den, quo, fnum, fden;
  logic [31:0] val, mag, quot;
  logic [31:0] sword, vn, vd;
  logic signed [33:0] a_ext, tol_ext;

  // R16 one tick per millisecond
  assign TICK = (tick_cnt == TICK_CNT_W'(TICK_CYCLES - 1));
  assign next_tick_cnt = TICK ? '0 : tick_cnt + 1'b1;
  assign IMM_STOP = FAULT;

  // a change counts only once the last two stages agree
  assign next_lim_stable = (lim_s2 == lim_s3) ? lim_s3 : lim_stable;

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      tick_cnt <= '0;
      lim_s1 <= '0;
      lim_s2 <= '0;
      lim_s3 <= '0;
      lim_stable <= '0;
    end else begin
      tick_cnt <= next_tick_cnt;
      lim_s1 <= {LIMIT_POS, LIMIT_NEG};
      lim_s2 <= lim_s1;
      lim_s3 <= lim_s2;
      lim_stable <= next_lim_stable;
    end
  end

  function automatic int slot_of(input logic [15:0] ix, input logic [7:0] sb);
    case ({ix, sb})
      {OBJ_ENC, SUB_NUM}: slot_of = S_ENC_INC;
      {OBJ_ENC, SUB_DEN}: slot_of = S_ENC_REV;
      {OBJ_GEAR, SUB_NUM}: slot_of = S_GEAR_M;
      {OBJ_GEAR, SUB_DEN}: slot_of = S_GEAR_S;
      {OBJ_FEED, SUB_NUM}: slot_of = S_FEED;
      {OBJ_FEED, SUB_DEN}: slot_of = S_FEED_S;
      {OBJ_VFAC, SUB_NUM}: slot_of = S_VNUM;
      {OBJ_VFAC, SUB_DEN}: slot_of = S_VDEN;
      {OBJ_AFAC, SUB_NUM}: slot_of = S_ANUM;
      {OBJ_AFAC, SUB_DEN}: slot_of = S_ADEN;
      {OBJ_JFAC, SUB_NUM}: slot_of = S_JNUM;
      {OBJ_JFAC, SUB_DEN}: slot_of = S_JDEN;
      {OBJ_POSU, SUB_WORD}: slot_of = S_POSU;
      {OBJ_SPDU, SUB_WORD}: slot_of = S_SPDU;
      {OBJ_VMFAC, SUB_NUM}: slot_of = S_VMNUM;
      {OBJ_VMFAC, SUB_DEN}: slot_of = S_VMDEN;
      {OBJ_TOL, SUB_WORD}: slot_of = S_TOL;
      {OBJ_SWLIM, SUB_NUM}: slot_of = S_SWMIN;
      {OBJ_SWLIM, SUB_DEN}: slot_of = S_SWMAX;
      {OBJ_LIMEN, SUB_WORD}: slot_of = S_LIMEN;
      default: slot_of = S_NONE;
    endcase
  endfunction : slot_of

  always_comb begin
    slot = slot_of(OBJ_INDEX, OBJ_SUB);
    next_pend = pend;
    next_act = act;
    next_ack = OBJ_REQ;
    next_err = 1'b0;
    next_rdata = OBJ_RDATA;
    if (OBJ_REQ) begin
      if (OBJ_INDEX == OBJ_STAT && OBJ_SUB == SUB_WORD) begin
        next_err = OBJ_WE;
        next_rdata = OBJ_WE ? OBJ_RDATA : {27'h0, (pend != act), lim_act, CMD_REJECT, FAULT};
      end else if (slot == S_NONE) begin
        next_err = 1'b1;
      end else if (OBJ_WE) begin
        // R5 R6 reserved low bits of the unit words stay zero
        if (slot == S_POSU) next_pend[slot] = OBJ_WDATA & POSU_MASK;
        else if (slot == S_SPDU) next_pend[slot] = OBJ_WDATA & SPDU_MASK;
        else next_pend[slot] = OBJ_WDATA;
      end else begin
        next_rdata = pend[slot];
      end
    end
    // R18 new scaling only taken over outside operation-enabled
    if (TICK && !OP_ENABLED) next_act = pend;
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < NSLOT; i++) begin
        pend[i] <= SLOT_RESET[i];
        act[i] <= SLOT_RESET[i];
      end
      OBJ_ACK <= 1'b0;
      OBJ_ERR <= 1'b0;
      OBJ_RDATA <= '0;
    end else begin
      pend <= next_pend;
      act <= next_act;
      OBJ_ACK <= next_ack;
      OBJ_ERR <= next_err;
      OBJ_RDATA <= next_rdata;
    end
  end

  // R20 exponent magnitude saturates at six
  function automatic logic [CW-1:0] pow10(input logic [7:0] m);
    case (m)
      8'h00: pow10 = CW'(1);
      8'h01: pow10 = CW'(10);
      8'h02: pow10 = CW'(100);
      8'h03: pow10 = CW'(1000);
      8'h04: pow10 = CW'(10000);
      8'h05: pow10 = CW'(100000);
      default: pow10 = CW'(1000000);
    endcase
  endfunction : pow10

  // R1 R2 R3 R4 R19 user position unit to encoder increments
  function automatic logic [CW-1:0] pos_num(input logic [31:0] w);
    logic [7:0] u;
    logic signed [7:0] e;
    logic [CW-1:0] f;
    u = w[POS_UNIT_LSB +: 8];
    e = w[EXP_LSB +: 8];
    f = CW'(1);
    if (u != UNIT_INC) f = CW'(act[S_ENC_INC]) * CW'(act[S_GEAR_M]);
    if (u == UNIT_METER || u == UNIT_DIMLESS) f = f * CW'(act[S_FEED_S]);
    if (e > 0) f = f * pow10((e > EXP_MAX) ? 8'h06 : e);
    pos_num = f;
  endfunction : pos_num

  function automatic logic [CW-1:0] pos_den(input logic [31:0] w);
    logic [7:0] u;
    logic signed [7:0] e;
    logic [CW-1:0] f;
    u = w[POS_UNIT_LSB +: 8];
    e = w[EXP_LSB +: 8];
    f = CW'(1);
    if (u != UNIT_INC) f = CW'(act[S_ENC_REV]) * CW'(act[S_GEAR_S]);
    if (u == UNIT_METER || u == UNIT_DIMLESS) f = f * CW'(act[S_FEED]);
    if (u == UNIT_DEGREE) f = f * CW'(DEG_PER_REV);
    if (e < 0) f = f * pow10((e < -EXP_MAX) ? 8'h06 : 8'(-e));
    pos_den = f;
  endfunction : pos_den

  // R6 seconds per time unit of the speed word
  function automatic logic [31:0] time_sec(input logic [7:0] t);
    case (t)
      TIME_MIN: time_sec = SEC_PER_MIN;
      TIME_HOUR: time_sec = SEC_PER_HOUR;
      TIME_DAY: time_sec = SEC_PER_DAY;
      TIME_YEAR: time_sec = SEC_PER_YEAR;
      default: time_sec = 32'h00000001;
    endcase
  endfunction : time_sec

  // shared divider, one quantity per cycle
  always_comb begin
    // R7 velocity mode is fixed rpm with its own factor
    sword = velmode ? POSU_RPM_WORD : act[S_SPDU];
    vn = velmode ? act[S_VMNUM] : act[S_VNUM];
    vd = velmode ? act[S_VMDEN] : act[S_VDEN];
    fnum = pos_num(sword);
    fden = pos_den(sword) * CW'(time_sec(sword[TIME_LSB +: 8]));
    val = '0;
    case (item)
      IT_POS: begin
        val = snap[0];
        fnum = pos_num(act[S_POSU]);
        fden = pos_den(act[S_POSU]);
      end
      // R8 velocity ratio
      IT_SPD: begin
        val = snap[1];
        fnum = fnum * CW'(vn);
        fden = fden * CW'(vd);
      end
      // R9 acceleration ratio per second
      IT_ACC: begin
        val = snap[2];
        fnum = fnum * CW'(act[S_ANUM]);
        fden = fden * CW'(act[S_ADEN]);
      end
      // R10 jerk ratio per second
      IT_JRK: begin
        val = snap[3];
        fnum = fnum * CW'(act[S_JNUM]);
        fden = fden * CW'(act[S_JDEN]);
      end
      IT_MIN, IT_MAX: begin
        val = (item == IT_MIN) ? act[S_SWMIN] : act[S_SWMAX];
        fnum = pos_num(act[S_POSU]);
        fden = pos_den(act[S_POSU]);
      end
      default: val = '0;
    endcase
    // R21 full-width products, one division at the end
    num = CW'(val[31] ? 32'(-val) : val) * fnum;
    den = fden;
    quo = (den == '0) ? '0 : num / den;
    mag = (|quo[CW-1:31]) ? 32'h7FFFFFFF : quo[31:0];
    quot = val[31] ? 32'(-mag) : mag;
  end

  always_comb begin
    next_state = state;
    next_item = item;
    next_snap = snap;
    next_res = res;
    next_apos = apos;
    next_velmode = velmode;
    next_lim_act = lim_act;
    next_ref_neg = ref_neg;
    next_ref_pos = ref_pos;
    next_demand = DEMAND_POS;
    next_speed = SPEED_DEMAND;
    next_accel = ACCEL_DEMAND;
    next_jerk = JERK_DEMAND;
    next_reject = 1'b0;
    forbidden = 1'b0;
    a_ext = $signed({{2{ACTUAL_POS[31]}}, ACTUAL_POS});
    tol_ext = $signed({2'b00, act[S_TOL]});
    if (TICK) begin
      // R17 one sample of targets, actual position, velocity mode and limits per tick
      next_snap = '{TARGET_POS, TARGET_SPEED, TARGET_ACCEL, TARGET_JERK};
      next_apos = ACTUAL_POS;
      next_velmode = VELOCITY_MODE;
      // R11 only enabled inputs act as limit switches
      next_lim_act = lim_stable & act[S_LIMEN][1:0];
      if (next_lim_act[0] && !lim_act[0]) next_ref_neg = ACTUAL_POS;
      if (next_lim_act[1] && !lim_act[1]) next_ref_pos = ACTUAL_POS;
      // R12 free inside the tolerance zone past the switch
      if (next_lim_act[0] && a_ext < $signed({{2{next_ref_neg[31]}}, next_ref_neg}) - tol_ext)
        forbidden = 1'b1;
      if (next_lim_act[1] && a_ext > $signed({{2{next_ref_pos[31]}}, next_ref_pos}) + tol_ext)
        forbidden = 1'b1;
    end
    case (state)
      UUSL_IDLE: begin
        if (TICK) begin
          next_state = UUSL_CALC;
          next_item = IT_POS;
        end
      end
      UUSL_CALC: begin
        next_res[item] = quot;
        if (item == 3'(NITEM - 1)) next_state = UUSL_APPLY;
        else next_item = item + 3'h1;
      end
      UUSL_APPLY: begin
        next_state = UUSL_IDLE;
        if (!FAULT) begin
          // R15 outside the range only moves back toward it
          if (($signed(apos) > $signed(res[IT_MAX]) && $signed(res[IT_POS]) > $signed(apos)) ||
              ($signed(apos) < $signed(res[IT_MIN]) && $signed(res[IT_POS]) < $signed(apos))) begin
            next_reject = 1'b1;
          end else if ($signed(res[IT_POS]) > $signed(res[IT_MAX])) begin
            // R14 clamp to the software limits
            next_demand = res[IT_MAX];
          end else if ($signed(res[IT_POS]) < $signed(res[IT_MIN])) begin
            next_demand = res[IT_MIN];
          end else begin
            next_demand = res[IT_POS];
          end
          next_speed = res[IT_SPD];
          next_accel = res[IT_ACC];
          next_jerk = res[IT_JRK];
        end
      end
      default: next_state = UUSL_IDLE;
    endcase
    // R13 forbidden range: hold position, fault; set beats clear
    next_fault = forbidden | (FAULT & ~FAULT_RESET);
    if (forbidden) begin
      next_demand = ACTUAL_POS;
      next_speed = '0;
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state <= UUSL_IDLE;
      item <= IT_POS;
      snap <= '{4{32'h00000000}};
      res <= '{NITEM{32'h00000000}};
      apos <= '0;
      velmode <= 1'b0;
      lim_act <= '0;
      ref_neg <= '0;
      ref_pos <= '0;
      DEMAND_POS <= '0;
      SPEED_DEMAND <= '0;
      ACCEL_DEMAND <= '0;
      JERK_DEMAND <= '0;
      FAULT <= 1'b0;
      CMD_REJECT <= 1'b0;
    end else begin
      state <= next_state;
      item <= next_item;
      snap <= next_snap;
      res <= next_res;
      apos <= next_apos;
      velmode <= next_velmode;
      lim_act <= next_lim_act;
      ref_neg <= next_ref_neg;
      ref_pos <= next_ref_pos;
      DEMAND_POS <= next_demand;
      SPEED_DEMAND <= next_speed;
      ACCEL_DEMAND <= next_accel;
      JERK_DEMAND <= next_jerk;
      FAULT <= next_fault;
      CMD_REJECT <= next_reject;
    end
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  a_tick_spacing: assert property (TICK |=> !TICK [*8]) // R16
    else $error("tick repeated too soon");
  a_calc_latency: assert property (TICK && state == UUSL_IDLE |-> ##7 state == UUSL_APPLY) // R17
    else $error("apply not seven cycles after tick");
  a_demand_clamp: assert property (state == UUSL_APPLY && !FAULT && !next_reject && !forbidden
      && $signed(res[IT_MIN]) <= $signed(res[IT_MAX])
      |=> $signed(DEMAND_POS) <= $signed(res[IT_MAX]) && $signed(DEMAND_POS) >= $signed(res[IT_MIN])) // R14
    else $error("demand outside software limits");
  a_reject_hold: assert property (CMD_REJECT |-> $stable(DEMAND_POS)) // R15
    else $error("rejected command moved demand");
  a_forbidden_stop: assert property (forbidden |=> FAULT && IMM_STOP && DEMAND_POS == $past(ACTUAL_POS)) // R13
    else $error("forbidden range did not stop");
  a_fault_sticky: assert property (FAULT && !FAULT_RESET |=> FAULT) // R13
    else $error("fault dropped without reset");
  a_cfg_frozen: assert property (OP_ENABLED |=> $stable(act[S_GEAR_M]) && $stable(act[S_POSU])) // R18
    else $error("scaling changed while operation enabled");
  a_cfg_taken: assert property (TICK && !OP_ENABLED |=> act[S_SPDU] == $past(pend[S_SPDU])) // R18
    else $error("pending scaling not taken over");
  a_posu_reserved: assert property (pend[S_POSU][POS_UNIT_LSB-1:0] == '0) // R5
    else $error("position word reserved bits set");
  a_limit_enable: assert property (TICK |=> (lim_act & ~$past(act[S_LIMEN][1:0])) == 2'b00) // R11
    else $error("disabled input acting as limit");
  a_obj_answer: assert property (OBJ_REQ |=> OBJ_ACK ##1 !OBJ_ACK || $past(OBJ_REQ, 1))
    else $error("object request not answered");

  c_forbidden: cover property (forbidden ##1 FAULT);
  c_reject: cover property (CMD_REJECT);
  c_velmode_apply: cover property (velmode && state == UUSL_APPLY);
  c_cfg_write: cover property (OBJ_REQ && OBJ_WE && slot == S_POSU ##[1:200] TICK && !OP_ENABLED);

endmodule : uusl_core

//--- uusl_motor_model.sv
`timescale 1ns/1ps
module uusl_motor_model #(
  parameter int STEP = 16,
  parameter int LIMIT_AT = 2000
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic tick,
  input wire logic [31:0] demand_pos,
  input wire logic place_en,
  input wire logic [31:0] place_pos,
  output logic [31:0] actual_pos,
  output logic limit_neg,
  output logic limit_pos
);
  logic signed [31:0] actual;
  logic signed [31:0] next_actual;
  logic signed [31:0] diff;

  assign actual_pos = actual;
  // switches at fixed shaft positions; contacts modelled without bounce
  assign limit_pos = (actual >= LIMIT_AT);
  assign limit_neg = (actual <= -LIMIT_AT);

  always_comb begin
    diff = $signed(demand_pos) - actual;
    next_actual = actual;
    if (place_en) begin
      next_actual = $signed(place_pos);
    end else if (tick) begin
      // a slow axis: STEP caps travel per tick so demand is not met at once
      if (diff > STEP) begin
        next_actual = actual + STEP;
      end else if (diff < -STEP) begin
        next_actual = actual - STEP;
      end else begin
        next_actual = $signed(demand_pos);
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      actual <= 32'h00000000;
    end else begin
      actual <= next_actual;
    end
  end
endmodule : uusl_motor_model

//--- tb_user_unit_scaling_limits.sv
`timescale 1ns/1ps
module tb_user_unit_scaling_limits
  import uusl_pkg::*;
;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic obj_req = 1'h0;
  logic obj_we = 1'h0;
  logic [15:0] obj_index = 16'h0000;
  logic [7:0] obj_sub = 8'h00;
  logic [31:0] obj_wdata = 32'h00000000;
  logic [31:0] t_pos = 32'h00000000;
  logic [31:0] t_spd = 32'h0000001E;
  logic [31:0] t_acc = 32'h0000003C;
  logic [31:0] t_jrk = 32'h00000078;
  logic [31:0] place_pos = 32'h00000000;
  logic op_en = 1'h0;
  logic vel_mode = 1'h0;
  logic fault_reset = 1'h0;
  logic place_en = 1'h1;
  wire logic obj_ack, obj_err, limit_neg, limit_pos, fault, imm_stop, cmd_reject, tick;
  wire logic [31:0] obj_rdata, actual_pos, demand_pos, speed_demand, accel_demand, jerk_demand;
  int miscompares = 0;
  int comparisons = 0;
  int rejects = 0;
  int k;

  always #4 clock = ~clock;
  always @(negedge clock) if (cmd_reject === 1'h1) rejects++;

  uusl_core #(.TICK_CYCLES(16)) u_dut (.CLOCK(clock), .RST(rst), .OBJ_REQ(obj_req),
    .OBJ_WE(obj_we), .OBJ_INDEX(obj_index), .OBJ_SUB(obj_sub), .OBJ_WDATA(obj_wdata),
    .OBJ_ACK(obj_ack), .OBJ_ERR(obj_err), .OBJ_RDATA(obj_rdata), .TARGET_POS(t_pos),
    .TARGET_SPEED(t_spd), .TARGET_ACCEL(t_acc), .TARGET_JERK(t_jrk),
    .ACTUAL_POS(actual_pos), .LIMIT_NEG(limit_neg), .LIMIT_POS(limit_pos),
    .OP_ENABLED(op_en), .VELOCITY_MODE(vel_mode), .FAULT_RESET(fault_reset),
    .DEMAND_POS(demand_pos), .SPEED_DEMAND(speed_demand), .ACCEL_DEMAND(accel_demand),
    .JERK_DEMAND(jerk_demand), .FAULT(fault), .IMM_STOP(imm_stop),
    .CMD_REJECT(cmd_reject), .TICK(tick));

  uusl_motor_model #(.STEP(16), .LIMIT_AT(2000)) u_motor (.clock(clock), .rst(rst),
    .tick(tick), .demand_pos(demand_pos), .place_en(place_en), .place_pos(place_pos),
    .actual_pos(actual_pos), .limit_neg(limit_neg), .limit_pos(limit_pos));

  task automatic close_out();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask : chk

  // one access; on reads d is the expected data
  task automatic acc(input logic w, input logic [15:0] ix, input logic [7:0] sb,
                     input logic [31:0] d, input logic e);
    @(posedge clock);
    obj_req <= 1'h1;
    obj_we <= w;
    obj_index <= ix;
    obj_sub <= sb;
    obj_wdata <= d;
    @(posedge clock);
    obj_req <= 1'h0;
    #1;
    chk(obj_ack, 32'h1, "ack");
    chk(obj_err, e, "err flag");
    if (!w) chk(obj_rdata, d, "read data");
  endtask : acc

  task automatic ratio(input logic [15:0] ix, input logic [31:0] n, input logic [31:0] d);
    acc(1'h1, ix, SUB_NUM, n, 1'h0);
    acc(1'h1, ix, SUB_DEN, d, 1'h0);
  endtask : ratio

  // waits out n ticks plus the update latency
  task automatic tk(input int n);
    int c;
    repeat (n) begin
      c = 0;
      @(negedge clock);
      while (tick !== 1'h1 && c < 40) begin
        @(negedge clock);
        c++;
      end
      if (c >= 40) begin
        miscompares++;
        close_out();
      end
      repeat (10) @(posedge clock);
    end
    #1;
  endtask : tk

  task automatic pos_chk(input logic [31:0] p, input logic [31:0] e, input string m);
    @(posedge clock);
    t_pos <= p;
    tk(2);
    chk(demand_pos, e, m);
  endtask : pos_chk

  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'h0;
    acc(1'h0, OBJ_POSU, SUB_WORD, 32'hFF410000, 1'h0);
    acc(1'h0, OBJ_SPDU, SUB_WORD, 32'h00B44700, 1'h0);
    // an refused read leaves the last read data standing
    acc(1'h0, 16'h1234, SUB_WORD, 32'h00B44700, 1'h1);
    acc(1'h1, OBJ_STAT, SUB_WORD, 32'h00000001, 1'h1);
    acc(1'h1, OBJ_POSU, SUB_WORD, 32'hFD010005, 1'h0);
    acc(1'h0, OBJ_POSU, SUB_WORD, 32'hFD010000, 1'h0);
    acc(1'h1, OBJ_SPDU, SUB_WORD, 32'hFD0103FF, 1'h0);
    acc(1'h0, OBJ_SPDU, SUB_WORD, 32'hFD010300, 1'h0);
    acc(1'h1, OBJ_SPDU, SUB_WORD, 32'h00B44700, 1'h0);
    acc(1'h1, OBJ_POSU, SUB_WORD, 32'hFF410000, 1'h0);
    tk(1);
    k = 0;
    while (tick !== 1'h1 && k < 40) begin
      @(negedge clock);
      k++;
    end
    // count idle cycles from the tick just seen to the next one
    k = 0;
    @(negedge clock);
    while (tick !== 1'h1 && k < 40) begin
      @(negedge clock);
      k++;
    end
    chk(k, 15, "tick spacing");
    $display("test registers done");
    ratio(OBJ_ENC, 32'h00001F40, 32'h00000001);
    pos_chk(32'h00000708, 1800 * 8000 / 3600, "tenth degree");
    ratio(OBJ_GEAR, 32'h00000002, 32'h00000001);
    pos_chk(32'h00000708, 1800 * 8000 * 2 / 3600, "gear");
    ratio(OBJ_GEAR, 32'h00000001, 32'h00000001);
    ratio(OBJ_FEED, 32'h00000002, 32'h00000001);
    pos_chk(32'h00000708, 1800 * 8000 / 3600, "degree ignores feed");
    acc(1'h1, OBJ_POSU, SUB_WORD, 32'hFD010000, 1'h0);
    pos_chk(32'h0000000A, 10 * 8000 / (2 * 1000), "millimeter");
    acc(1'h1, OBJ_POSU, SUB_WORD, 32'h00010000, 1'h0);
    pos_chk(32'h00000001, 8000 / 2, "meter exp 0");
    acc(1'h1, OBJ_POSU, SUB_WORD, 32'h02B40000, 1'h0);
    pos_chk(32'h00000001, 8000 * 100, "rev exp +2");
    $display("test position done");
    ratio(OBJ_ENC, 32'h00000258, 32'h00000001);
    ratio(OBJ_VFAC, 32'h00000002, 32'h00000001);
    ratio(OBJ_AFAC, 32'h00000003, 32'h00000001);
    ratio(OBJ_JFAC, 32'h00000001, 32'h00000002);
    tk(2);
    chk(speed_demand, 30 * 600 * 2 / 60, "speed");
    chk(accel_demand, 60 * 600 * 3 / 60, "accel");
    chk(jerk_demand, 120 * 600 / (2 * 60), "jerk");
    acc(1'h1, OBJ_SPDU, SUB_WORD, 32'h00B50300, 1'h0);
    ratio(OBJ_VMFAC, 32'h00000003, 32'h00000001);
    @(posedge clock);
    vel_mode <= 1'h1;
    tk(2);
    chk(speed_demand, 30 * 600 * 3 / 60, "velocity mode rpm");
    @(posedge clock);
    vel_mode <= 1'h0;
    tk(2);
    chk(speed_demand, 30 * 2, "increments per s");
    @(posedge clock);
    op_en <= 1'h1;
    ratio(OBJ_VFAC, 32'h00000004, 32'h00000001);
    acc(1'h0, OBJ_VFAC, SUB_NUM, 32'h00000004, 1'h0);
    tk(2);
    chk(speed_demand, 30 * 2, "held while enabled");
    @(posedge clock);
    op_en <= 1'h0;
    tk(2);
    chk(speed_demand, 30 * 4, "applied after leaving");
    $display("test speed done");
    acc(1'h1, OBJ_POSU, SUB_WORD, 32'h00B50000, 1'h0);
    acc(1'h1, OBJ_SWLIM, SUB_NUM, 32'hFFFFFF9C, 1'h0);
    acc(1'h1, OBJ_SWLIM, SUB_DEN, 32'h00000064, 1'h0);
    pos_chk(32'h000001F4, 32'h00000064, "clamp max");
    pos_chk(32'hFFFFFE0C, 32'hFFFFFF9C, "clamp min");
    @(posedge clock);
    place_pos <= 32'h000000C8;
    k = rejects;
    pos_chk(32'h0000012C, 32'hFFFFFF9C, "outward refused");
    // the outward target stands for two ticks, so two refusals
    chk(rejects, k + 2, "reject pulse");
    pos_chk(32'h00000032, 32'h00000032, "inward accepted");
    chk(rejects, k + 2, "no reject");
    @(posedge clock);
    place_en <= 1'h0;
    tk(12);
    chk(actual_pos, 32'h00000032, "slow follow");
    acc(1'h1, OBJ_SWLIM, SUB_NUM, 32'h80000000, 1'h0);
    acc(1'h1, OBJ_SWLIM, SUB_DEN, 32'h7FFFFFFF, 1'h0);
    $display("test soft limits done");
    @(posedge clock);
    place_en <= 1'h1;
    place_pos <= 32'h00000BB8;
    acc(1'h1, OBJ_TOL, SUB_WORD, 32'h0000000A, 1'h0);
    tk(3);
    chk(fault, 32'h0, "switch disabled");
    acc(1'h1, OBJ_LIMEN, SUB_WORD, 32'h00000002, 1'h0);
    tk(3);
    @(posedge clock);
    place_pos <= 32'h00000BBD;
    tk(3);
    chk(fault, 32'h0, "inside tolerance");
    @(posedge clock);
    place_pos <= 32'h00000BC3;
    k = 0;
    while (fault !== 1'h1 && k < 60) begin
      @(negedge clock);
      k++;
    end
    chk(fault, 32'h1, "forbidden fault");
    chk(imm_stop, 32'h1, "stop");
    chk(speed_demand, 32'h0, "speed zero");
    chk(demand_pos, 32'h00000BC3, "hold actual");
    acc(1'h0, OBJ_STAT, SUB_WORD, 32'h00000009, 1'h0);
    @(posedge clock);
    place_pos <= 32'h00000000;
    tk(2);
    @(posedge clock);
    fault_reset <= 1'h1;
    @(posedge clock);
    fault_reset <= 1'h0;
    repeat (2) @(posedge clock);
    #1;
    chk(fault, 32'h0, "fault cleared");
    $display("test hard limits done");
    close_out();
  end
endmodule : tb_user_unit_scaling_limits
